/* peh_pkg.sv */
// Purpose: constants and carriers for the precise exception history unit
// Assumes: 32-bit data, single core clock
// Notes: status word bit positions and register offsets are fixed here
package peh_pkg;
   // ****************************************************
   // sizes
   // ****************************************************
   localparam int HB_DEPTH = 16;
   localparam int VEC_W = 9;
   localparam int HW_VEC_LIMIT = 128;
   localparam int SCRATCH_N = 5;
   localparam int APB_AW = 8;
   localparam logic [3:0] PC_STEP = 4'h4;
   // ****************************************************
   // register offsets
   // ****************************************************
   localparam logic [7:0] OFS_VBASE = 8'h00;
   localparam logic [7:0] OFS_PSW = 8'h04;
   localparam logic [7:0] OFS_SAVED_PTR = 8'h08;
   localparam logic [7:0] OFS_SAVED_STAT = 8'h0C;
   localparam logic [7:0] OFS_EXEC_PTR = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_SCRATCH0 = 8'h20;
   // ****************************************************
   // status word fields and reset values
   // ****************************************************
   localparam int PSW_SUPER = 31;
   localparam int PSW_UNIT_DIS = 3;
   localparam int PSW_INT_DIS = 1;
   localparam int PSW_FREEZE = 0;
   localparam logic [31:0] PSW_RST = 32'h8000_000B;
   localparam logic [31:0] VBASE_RST = 32'h0000_0000;
   // ****************************************************
   // carriers
   // ****************************************************
   typedef struct packed {
      logic [31:0] pc;
      logic dslot;
      logic has_dest;
      logic [4:0] dest;
      logic [31:0] old_val;
      logic is_store;
      logic is_touch;
      logic [31:0] st_addr;
      logic [31:0] st_data;
   } peh_issue_t;
   typedef struct packed {
      logic valid;
      logic [3:0] idx;
      logic exc;
      logic trap;
      logic [VEC_W-1:0] vec;
   } peh_comp_t;
   typedef struct packed {
      logic valid;
      logic [4:0] dest;
      logic [31:0] value;
   } peh_undo_t;
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [31:0] data;
   } peh_commit_t;
   typedef struct packed {
      logic valid;
      logic is_rte;
      logic [31:0] addr;
   } peh_redir_t;
   typedef enum logic [2:0] {
      ST_RUN, ST_RESTORE, ST_SAVE1, ST_SAVE2, ST_RTE
   } peh_state_t;
endpackage : peh_pkg

/* peh_unit.sv */
// Purpose: history queue, precise exception entry and return sequencing
// Assumes: one issue per cycle; pipeline obeys undo and redirect outputs
// Notes: apb slave answers with one access cycle
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module peh_unit
   import peh_pkg::*;
#(
   parameter int DEPTH = HB_DEPTH,
   parameter logic [VEC_W-1:0] ERR_VEC = 9'h001,
   parameter logic [VEC_W-1:0] PRIV_VEC = 9'h002,
   parameter logic [VEC_W-1:0] INT_VEC = 9'h003
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic iss_valid_i,
   input wire peh_issue_t iss_i,
   output logic iss_ready_o,
   output logic [3:0] iss_idx_o,
   input wire peh_comp_t comp_i,
   input wire logic rte_i,
   input wire logic irq_i,
   input wire logic xcr_valid_i,
   input wire logic [2:0] xcr_sel_i,
   input wire logic [31:0] xcr_wdata_i,
   output logic [31:0] xcr_rdata_o,
   output logic xcr_fault_o,
   output peh_undo_t undo0_o,
   output peh_undo_t undo1_o,
   output peh_commit_t commit_o,
   output peh_redir_t redir_o,
   output logic [31:0] psw_o
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
   localparam logic [PW:0] TWO = (PW+1)'(2);

   if (DEPTH != 16) begin : g_depth_check
      $error("history depth must be 16");
   end

   // ****************************************************
   // reset and pin synchronisers
   // ****************************************************
   logic rst_s1_r, rst_n;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   logic irq_s1_r, irq_s2_r;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_s1_r <= 1'b0;
         irq_s2_r <= 1'b0;
      end else begin
         irq_s1_r <= irq_i;
         irq_s2_r <= irq_s1_r;
      end
   end

   // ****************************************************
   // state
   // ****************************************************
   peh_state_t state_r, state_nxt;
   logic [PW-1:0] head_r, tail_r, ptr_r;
   logic [PW:0] cnt_r, cnt_nxt, rem_r;
   logic [31:0] vbase_r, psw_r, sptr_r, sstat_r, xptr_r;
   logic [31:0] scratch_r [SCRATCH_N];
   logic [31:0] flt_pc_r;
   logic flt_ds_r;
   logic [VEC_W-1:0] flt_vec_r;
   logic iss_ready_r;
   peh_issue_t e_ins [DEPTH];
   logic [DEPTH-1:0] e_done_r, e_exc_r;
   logic [VEC_W-1:0] e_vec_r [DEPTH];

   // ****************************************************
   // queue decisions
   // ****************************************************
   logic active, tail_done, take_exc, take_int, recog, retire, do_iss;
   logic frozen;
   assign active = (state_r == ST_RUN) || (state_r == ST_RTE);
   assign frozen = psw_r[PSW_FREEZE];
   assign tail_done = (cnt_r != '0) && e_done_r[tail_r];
   assign take_exc = active && tail_done && e_exc_r[tail_r];
   assign take_int = active && tail_done && !e_exc_r[tail_r] &&
                     irq_s2_r && !psw_r[PSW_INT_DIS];
   assign recog = take_exc || take_int;
   assign retire = active && tail_done && !e_exc_r[tail_r];
   assign do_iss = iss_valid_i && iss_ready_r && !recog &&
                   (state_r == ST_RUN);

   always_comb begin
      cnt_nxt = cnt_r;
      if (recog) begin
         cnt_nxt = '0;
      end else begin
         if (do_iss) cnt_nxt = cnt_nxt + 1'b1;
         if (retire) cnt_nxt = cnt_nxt - 1'b1;
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN: begin
            if (recog) begin
               state_nxt = ((take_int ? cnt_r - 1'b1 : cnt_r) == '0) ?
                           ST_SAVE1 : ST_RESTORE;
            end else if (rte_i) begin
               state_nxt = ST_RTE;
            end
         end
         ST_RESTORE: begin
            if (rem_r <= TWO) state_nxt = ST_SAVE1;
         end
         ST_SAVE1: state_nxt = ST_SAVE2;
         ST_SAVE2: state_nxt = ST_RUN;
         ST_RTE: begin
            if (recog) begin
               state_nxt = ((take_int ? cnt_r - 1'b1 : cnt_r) == '0) ?
                           ST_SAVE1 : ST_RESTORE;
            end else if (cnt_r == '0) begin
               state_nxt = ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_RUN;
         iss_ready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         iss_ready_r <= (cnt_nxt < FULL) && (state_nxt == ST_RUN);
      end
   end

   // ****************************************************
   // queue pointers and entry flags
   // ****************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         head_r <= '0;
         tail_r <= '0;
         cnt_r <= '0;
         e_done_r <= '0;
         e_exc_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         if (comp_i.valid) begin
            e_done_r[comp_i.idx[PW-1:0]] <= 1'b1;
            e_exc_r[comp_i.idx[PW-1:0]] <=
               !e_ins[comp_i.idx[PW-1:0]].is_touch &&
               (comp_i.exc || (comp_i.trap &&
                comp_i.vec < VEC_W'(HW_VEC_LIMIT)));
         end
         if (do_iss) begin
            e_done_r[head_r] <= 1'b0;
            e_exc_r[head_r] <= 1'b0;
         end
         if (recog) begin
            head_r <= tail_r + PW'(retire);
            tail_r <= tail_r + PW'(retire);
         end else begin
            if (do_iss) head_r <= head_r + 1'b1;
            if (retire) tail_r <= tail_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (do_iss) begin
         e_ins[head_r] <= iss_i;
      end
      if (comp_i.valid) begin
         if (comp_i.trap && comp_i.vec < VEC_W'(HW_VEC_LIMIT)) begin
            e_vec_r[comp_i.idx[PW-1:0]] <= PRIV_VEC;
         end else begin
            e_vec_r[comp_i.idx[PW-1:0]] <= comp_i.vec;
         end
      end
   end

   // ****************************************************
   // store release at tail
   // ****************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         commit_o <= '0;
      end else begin
         commit_o.valid <= retire && e_ins[tail_r].is_store;
         commit_o.addr <= e_ins[tail_r].st_addr;
         commit_o.data <= e_ins[tail_r].st_data;
      end
   end

   // ****************************************************
   // fault capture and reverse restore walk
   // ****************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         flt_pc_r <= '0;
         flt_ds_r <= 1'b0;
         flt_vec_r <= '0;
         ptr_r <= '0;
         rem_r <= '0;
         undo0_o <= '0;
         undo1_o <= '0;
      end else begin
         undo0_o.valid <= 1'b0;
         undo1_o.valid <= 1'b0;
         if (recog) begin
            ptr_r <= head_r - 1'b1;
            flt_vec_r <= frozen ? ERR_VEC :
                         (take_exc ? e_vec_r[tail_r] : INT_VEC);
            if (take_exc) begin
               flt_pc_r <= e_ins[tail_r].pc;
               flt_ds_r <= e_ins[tail_r].dslot;
               rem_r <= cnt_r;
            end else begin
               flt_pc_r <= e_ins[tail_r].pc + 32'(PC_STEP);
               flt_ds_r <= 1'b0;
               rem_r <= cnt_r - 1'b1;
            end
         end else if (state_r == ST_RESTORE) begin
            undo0_o.valid <= e_ins[ptr_r].has_dest;
            undo0_o.dest <= e_ins[ptr_r].dest;
            undo0_o.value <= e_ins[ptr_r].old_val;
            undo1_o.valid <= (rem_r >= TWO) &&
                             e_ins[ptr_r - 1'b1].has_dest;
            undo1_o.dest <= e_ins[ptr_r - 1'b1].dest;
            undo1_o.value <= e_ins[ptr_r - 1'b1].old_val;
            ptr_r <= ptr_r - PW'(2);
            rem_r <= (rem_r >= TWO) ? rem_r - TWO : '0;
         end
      end
   end

   // ****************************************************
   // status word, saved context, redirect
   // ****************************************************
   logic apb_wr;
   assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         psw_r <= PSW_RST;
         vbase_r <= VBASE_RST;
         sptr_r <= '0;
         sstat_r <= '0;
         xptr_r <= '0;
         redir_o <= '0;
      end else begin
         redir_o.valid <= 1'b0;
         if (apb_wr && paddr_i == OFS_VBASE) vbase_r <= pwdata_i;
         if (apb_wr && paddr_i == OFS_PSW) psw_r <= pwdata_i;
         if (apb_wr && paddr_i == OFS_SAVED_PTR) sptr_r <= pwdata_i;
         if (apb_wr && paddr_i == OFS_SAVED_STAT) sstat_r <= pwdata_i;
         if (state_r == ST_SAVE1) begin
            sptr_r <= {flt_pc_r[31:1], flt_ds_r};
            sstat_r <= psw_r;
            psw_r[PSW_INT_DIS] <= 1'b1;
            psw_r[PSW_UNIT_DIS] <= 1'b1;
            psw_r[PSW_FREEZE] <= 1'b1;
            psw_r[PSW_SUPER] <= 1'b1;
         end
         if (state_r == ST_SAVE2) begin
            redir_o.valid <= 1'b1;
            redir_o.is_rte <= 1'b0;
            redir_o.addr <= {vbase_r[31:12], flt_vec_r, 3'h0};
            xptr_r <= {vbase_r[31:12], flt_vec_r, 3'h0};
         end
         if (state_r == ST_RTE && !recog && cnt_r == '0) begin
            psw_r <= sstat_r;
            xptr_r <= {sptr_r[31:2], 2'h0};
            redir_o.valid <= 1'b1;
            redir_o.is_rte <= 1'b1;
            redir_o.addr <= {sptr_r[31:2], 2'h0};
         end
      end
   end

   // ****************************************************
   // supervisor scratch registers
   // ****************************************************
   logic scr_hit;
   logic [2:0] scr_idx;
   assign scr_idx = 3'((paddr_i - OFS_SCRATCH0) >> 2);
   assign scr_hit = paddr_i >= OFS_SCRATCH0 && paddr_i[1:0] == 2'h0 &&
                    scr_idx < 3'(SCRATCH_N) &&
                    paddr_i < OFS_SCRATCH0 + 8'(4 * SCRATCH_N);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SCRATCH_N; i++) scratch_r[i] <= '0;
         xcr_rdata_o <= '0;
         xcr_fault_o <= 1'b0;
      end else begin
         xcr_fault_o <= 1'b0;
         if (apb_wr && scr_hit) scratch_r[scr_idx] <= pwdata_i;
         if (xcr_valid_i) begin
            if (psw_r[PSW_SUPER] && xcr_sel_i < 3'(SCRATCH_N)) begin
               xcr_rdata_o <= scratch_r[xcr_sel_i];
               scratch_r[xcr_sel_i] <= xcr_wdata_i;
            end else begin
               xcr_fault_o <= 1'b1;
            end
         end
      end
   end

   // ****************************************************
   // apb slave
   // ****************************************************
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= '0;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= 1'b0;
         prdata_o <= '0;
         if (psel_i && !penable_i) begin
            unique case (paddr_i)
               OFS_VBASE: prdata_o <= vbase_r;
               OFS_PSW: prdata_o <= psw_r;
               OFS_SAVED_PTR: prdata_o <= sptr_r;
               OFS_SAVED_STAT: prdata_o <= sstat_r;
               OFS_EXEC_PTR: prdata_o <= xptr_r;
               OFS_STATUS: prdata_o <= {24'h0, 3'(state_r), cnt_r};
               default: begin
                  if (scr_hit) prdata_o <= scratch_r[scr_idx];
                  else pslverr_o <= 1'b1;
               end
            endcase
         end
      end
   end

   assign iss_ready_o = iss_ready_r;
   assign iss_idx_o = 4'(head_r);
   assign psw_o = psw_r;

   // ****************************************************
   // assertions
   // ****************************************************
   property p_full_stall;
      @(posedge clk_i) disable iff (!rst_n)
      cnt_r == FULL |-> !iss_ready_o;
   endproperty
   a_full_stall: assert property (p_full_stall)
      else $error("issue ready while queue full");

   property p_restore_len;
      @(posedge clk_i) disable iff (!rst_n)
      $rose(state_r == ST_RESTORE) |-> ##[1:8] state_r == ST_SAVE1;
   endproperty
   a_restore_len: assert property (p_restore_len)
      else $error("restore phase too long");

   property p_entry_time;
      @(posedge clk_i) disable iff (!rst_n)
      state_r == ST_SAVE1 |-> ##2 (redir_o.valid && !redir_o.is_rte);
   endproperty
   a_entry_time: assert property (p_entry_time)
      else $error("handler redirect not two cycles after restore");

   property p_save_stat;
      @(posedge clk_i) disable iff (!rst_n)
      state_r == ST_SAVE1 |=> sstat_r == $past(psw_r);
   endproperty
   a_save_stat: assert property (p_save_stat)
      else $error("saved status not copied");

   property p_entry_bits;
      @(posedge clk_i) disable iff (!rst_n)
      state_r == ST_SAVE1 |=> psw_r[PSW_INT_DIS] && psw_r[PSW_UNIT_DIS] &&
         psw_r[PSW_FREEZE] && psw_r[PSW_SUPER];
   endproperty
   a_entry_bits: assert property (p_entry_bits)
      else $error("entry status bits not set");

   property p_vec_addr;
      @(posedge clk_i) disable iff (!rst_n)
      redir_o.valid && !redir_o.is_rte |->
         redir_o.addr == {$past(vbase_r[31:12]), $past(flt_vec_r), 3'h0};
   endproperty
   a_vec_addr: assert property (p_vec_addr)
      else $error("handler address wrong");

   property p_store_hold;
      @(posedge clk_i) disable iff (!rst_n)
      commit_o.valid |-> $past(active) && !$past(e_exc_r[tail_r]);
   endproperty
   a_store_hold: assert property (p_store_hold)
      else $error("store released outside retirement");

   property p_priv;
      @(posedge clk_i) disable iff (!rst_n)
      comp_i.valid && comp_i.trap && comp_i.vec < VEC_W'(HW_VEC_LIMIT) |=>
         e_vec_r[$past(comp_i.idx[PW-1:0])] == PRIV_VEC;
   endproperty
   a_priv: assert property (p_priv)
      else $error("low trap vector not redirected");

   property p_touch;
      @(posedge clk_i) disable iff (!rst_n)
      comp_i.valid && e_ins[comp_i.idx[PW-1:0]].is_touch |=>
         !e_exc_r[$past(comp_i.idx[PW-1:0])];
   endproperty
   a_touch: assert property (p_touch)
      else $error("touch load logged an exception");

   property p_xcr_priv;
      @(posedge clk_i) disable iff (!rst_n)
      xcr_valid_i && !psw_r[PSW_SUPER] |=> xcr_fault_o;
   endproperty
   a_xcr_priv: assert property (p_xcr_priv)
      else $error("user exchange not refused");

   property p_rte;
      @(posedge clk_i) disable iff (!rst_n)
      state_r == ST_RTE && !recog && cnt_r == '0 |=>
         psw_r == $past(sstat_r) && redir_o.valid && redir_o.is_rte;
   endproperty
   a_rte: assert property (p_rte)
      else $error("return did not restore status");

   c_long_restore: cover property (@(posedge clk_i) disable iff (!rst_n)
      (state_r == ST_RESTORE) [*8]);
   c_interrupt: cover property (@(posedge clk_i) disable iff (!rst_n)
      take_int);
   c_full: cover property (@(posedge clk_i) disable iff (!rst_n)
      cnt_r == FULL && iss_valid_i);
   c_rte: cover property (@(posedge clk_i) disable iff (!rst_n)
      redir_o.valid && redir_o.is_rte);
endmodule : peh_unit

/* peh_pipe_model.sv */
// Purpose: completion side of the issue and execute pipeline
// Assumes: one pending completion at a time, fixed latency
// Notes: idle bus shows inverted old fields, never the last value
`timescale 1ns/1ns
module peh_pipe_model
   import peh_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire peh_comp_t req_c_i,
   input wire logic [3:0] lat_i,
   output peh_comp_t comp_o
);
   peh_comp_t hold_r;
   logic [3:0] cnt_r;
   logic busy_r;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold_r <= '0;
         cnt_r <= 4'h0;
         busy_r <= 1'b0;
         comp_o <= '0;
      end else begin
         comp_o <= ~hold_r;
         comp_o.valid <= 1'b0;
         if (req_i) begin
            hold_r <= req_c_i;
            cnt_r <= lat_i;
            busy_r <= 1'b1;
         end else if (busy_r && cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end else if (busy_r) begin
            comp_o <= hold_r;
            busy_r <= 1'b0;
         end
      end
   end
endmodule : peh_pipe_model

/* test_precise_exception_history_unit.sv */
// Purpose: self-checking bench for the exception history unit
// Assumes: default queue depth, error and privilege vectors 1 and 2
// Notes: outputs are read right after the edge that samples them
`timescale 1ns/1ns
module test_precise_exception_history_unit
   import peh_pkg::*;
;
   localparam logic [8:0] EV = 9'h001;
   localparam logic [8:0] PV = 9'h002;
   localparam logic [8:0] IV = 9'h003;
   localparam logic [31:0] VB = 32'hABCDE000;
   logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
   logic pwrite_i = 1'b0, iss_valid_i = 1'b0, rte_i = 1'b0, preq = 1'b0;
   logic xcr_valid_i = 1'b0, pready_o, pslverr_o, iss_ready_o, xcr_fault_o;
   logic irq_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [2:0] xcr_sel_i = 3'h0;
   logic [31:0] pwdata_i = 32'h0, xcr_wdata_i = 32'h0;
   logic [31:0] prdata_o, xcr_rdata_o, psw_o, q, lu;
   logic [3:0] iss_idx_o, ix, i0, i1, i2;
   logic pe;
   peh_issue_t iss_i = '0;
   peh_comp_t comp_i, pcmd = '0;
   peh_undo_t undo0_o, undo1_o;
   peh_commit_t commit_o, cm;
   peh_redir_t redir_o, rd;
   logic [8:0] cv [3] = '{9'd300, 9'd5, 9'd130};
   logic [8:0] ev [3] = '{EV, PV, 9'd130};
   int failures = 0, samples_checked = 0;
   int nrd = 0, nund = 0, ucyc = 0, ncm = 0;
   peh_unit #(.ERR_VEC(EV), .PRIV_VEC(PV), .INT_VEC(IV)) i_dut (.clk_i,
      .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .iss_valid_i, .iss_i, .iss_ready_o,
      .iss_idx_o, .comp_i, .rte_i, .irq_i, .xcr_valid_i, .xcr_sel_i,
      .xcr_wdata_i, .xcr_rdata_o, .xcr_fault_o, .undo0_o, .undo1_o,
      .commit_o, .redir_o, .psw_o);
   peh_pipe_model i_pipe (.clk_i, .rstn_i, .req_i(preq), .req_c_i(pcmd),
      .lat_i(4'h2), .comp_o(comp_i));
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (redir_o.valid === 1'b1) begin
         rd = redir_o;
         nrd++;
      end
      if (undo0_o.valid === 1'b1) begin
         ucyc++;
         lu = undo0_o.value;
      end
      nund += (undo0_o.valid === 1'b1) + (undo1_o.valid === 1'b1);
      if (commit_o.valid === 1'b1) begin
         cm = commit_o;
         ncm++;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task tmo(input int n);
      if (n >= 60) begin
         failures++;
         report_and_stop;
      end
   endtask : tmo
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 60);
      tmo(n);
      q = prdata_o;
      pe = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task iss(input logic [31:0] pc, input logic st, input logic tc,
            output logic [3:0] x);
      int n;
      n = 0;
      @(posedge clk_i);
      iss_valid_i <= 1'b1;
      iss_i <= '{pc, 1'b0, 1'b1, 5'h03, ~pc, st, tc, pc, ~pc};
      do begin
         @(posedge clk_i);
         n++;
      end while (iss_ready_o !== 1'b1 && n < 60);
      tmo(n);
      x = iss_idx_o;
      iss_valid_i <= 1'b0;
   endtask : iss
   task fin(input logic [3:0] x, input logic e, input logic t,
            input logic [8:0] v);
      @(posedge clk_i);
      preq <= 1'b1;
      pcmd <= '{1'b1, x, e, t, v};
      @(posedge clk_i);
      preq <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : fin
   task wred(input int k);
      int n;
      n = 0;
      while (nrd < k && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      tmo(n);
   endtask : wred
   task xcr(input logic [2:0] s, input logic [31:0] d);
      @(posedge clk_i);
      xcr_valid_i <= 1'b1;
      xcr_sel_i <= s;
      xcr_wdata_i <= d;
      @(posedge clk_i);
      xcr_valid_i <= 1'b0;
      @(posedge clk_i);
      q = xcr_rdata_o;
      pe = xcr_fault_o;
   endtask : xcr
   initial begin
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      apb(0, OFS_PSW, 0);
      chk(q, PSW_RST);
      apb(1, OFS_VBASE, VB);
      apb(0, OFS_VBASE, 0);
      chk(q, VB);
      apb(0, 8'hFC, 0);
      chk({31'h0, pe}, 32'h1);
      $display("test registers done");
      apb(1, OFS_PSW, 0);
      iss(32'h100, 0, 0, i0);
      iss(32'h104, 0, 0, i1);
      iss(32'h108, 0, 0, i2);
      fin(i1, 0, 0, 0);
      fin(i2, 0, 0, 0);
      chk(nrd, 0);
      fin(i0, 1, 0, 9'd200);
      wred(1);
      chk(rd.addr, {VB[31:12], 9'd200, 3'b000});
      chk(nund, 3);
      chk(ucyc, 2);
      chk(lu, ~32'h100);
      chk(psw_o & 32'h8000000B, 32'h8000000B);
      apb(0, OFS_SAVED_PTR, 0);
      chk(q, 32'h100);
      apb(0, OFS_SAVED_STAT, 0);
      chk(q, 32'h0);
      apb(0, OFS_EXEC_PTR, 0);
      chk(q, {VB[31:12], 9'd200, 3'b000});
      @(posedge clk_i);
      rte_i <= 1'b1;
      @(posedge clk_i);
      rte_i <= 1'b0;
      wred(2);
      chk({rd.addr[31:1], rd.is_rte}, 32'h101);
      chk(psw_o, 32'h0);
      apb(0, OFS_EXEC_PTR, 0);
      chk(q, 32'h100);
      $display("test exception and return done");
      for (int k = 0; k < 3; k++) begin
         apb(1, OFS_PSW, {31'h0, k == 0});
         iss(32'h200, 0, 0, ix);
         fin(ix, k != 1, k != 0, cv[k]);
         wred(k + 3);
         chk(rd.addr, {VB[31:12], ev[k], 3'b000});
      end
      $display("test vector selection done");
      iss(32'h300, 1, 0, ix);
      repeat (3) @(posedge clk_i);
      chk(ncm, 0);
      fin(ix, 0, 0, 0);
      repeat (4) @(posedge clk_i);
      chk(cm.addr ^ cm.data, 32'hFFFFFFFF);
      chk(cm.addr, 32'h300);
      iss(32'h304, 0, 1, ix);
      fin(ix, 1, 0, 9'd200);
      repeat (6) @(posedge clk_i);
      chk(nrd, 5);
      $display("test store and touch done");
      for (int k = 0; k < 16; k++) begin
         iss(k * 4, 0, 0, ix);
      end
      repeat (2) @(posedge clk_i);
      chk({31'h0, iss_ready_o}, 32'h0);
      fin(ix + 4'h1, 0, 0, 0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, iss_ready_o}, 32'h1);
      apb(0, OFS_STATUS, 0);
      chk(q, 32'h0000000F);
      $display("test full queue done");
      apb(1, OFS_PSW, PSW_RST);
      xcr(0, 32'h55);
      xcr(0, 32'h66);
      chk({q[30:0], pe}, 32'hAA);
      apb(0, OFS_SCRATCH0, 0);
      chk(q, 32'h66);
      apb(1, OFS_SCRATCH0 + 8'h10, 32'h77);
      xcr(4, 0);
      chk(q, 32'h77);
      xcr(5, 0);
      chk({31'h0, pe}, 32'h1);
      apb(1, OFS_PSW, 0);
      xcr(0, 0);
      chk({31'h0, pe}, 32'h1);
      $display("test scratch exchange done");
      irq_i <= 1'b1;
      fin(ix + 4'h2, 0, 0, 0);
      wred(6);
      irq_i <= 1'b0;
      chk(rd.addr, {VB[31:12], IV, 3'b000});
      chk(nund, 20);
      chk(ucyc, 12);
      apb(0, OFS_SAVED_PTR, 0);
      chk(q, 32'h8);
      $display("test interrupt done");
      report_and_stop;
   end
endmodule : test_precise_exception_history_unit
